// ==== rtl/spme_pkg.sv ====
// Constants for the serial program mode entry block
package spme_pkg;
   // ************************************************************
   // Link word and key geometry
   // ************************************************************
   localparam int KEY_WIDTH = 32;
   localparam int WORD_WIDTH = 32;
   localparam int BIT_CNT_WIDTH = 5;
   localparam logic [4:0] LAST_BIT = 5'h1f;
   localparam logic [5:0] READ_BITS = 6'h20;
   localparam int SYNC_STAGES = 3;
   // Field positions inside a link word: command, address, data
   localparam int CMD_MSB = 31;
   localparam int CMD_LSB = 24;
   localparam int ADDR_MSB = 23;
   localparam int ADDR_LSB = 16;
   localparam int DATA_MSB = 15;
   localparam int DATA_LSB = 0;
   // ************************************************************
   // Command codes and targets
   // ************************************************************
   localparam logic [7:0] CMD_WR_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_WR_USER_ID = 8'h03;
   localparam logic [7:0] CMD_WR_CONFIG = 8'h04;
   localparam logic [7:0] CMD_RD_STATUS = 8'h05;
   localparam logic [7:0] CFG_ADDR_LVP = 8'h00;
   localparam int LVP_DATA_BIT = 0;
   typedef enum logic [1:0] {SPME_TGT_PROGRAM, SPME_TGT_USER_ID, SPME_TGT_CONFIG} spme_target_e;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_SYNC = 3'h0;
   localparam logic [4:0] RST_BIT_CNT = 5'h00;
   localparam logic [5:0] RST_READ_CNT = 6'h00;
endpackage

// ==== rtl/spme_top.sv ====
// Serial program mode entry: pin qualification, key capture and session control
`timescale 1ns/1ps
// Notes on behaviour
// - The data pin is two-way and shared with the programmer, and the programmer drives the serial clock.
// - In a session, link words write program memory, user identification words and configuration bits.
// - High-voltage entry: clock and data held low, then the master clear pin goes to programming level.
// - Low-voltage entry is possible only while the low-voltage enable bit is 1 and refused while it is 0.
// - Low-voltage entry: master clear held low, then a 32-bit key shifted in one bit per serial clock.
// - After a good key the session lasts only while master clear stays low.
// - While the low-voltage enable bit is 1 the master clear reset function is forced on.
// - The low-voltage enable bit may be cleared only in a session entered at high voltage.
module spme_top
   import spme_pkg::*;
#(
   parameter logic [31:0] KEY_VALUE = 32'h5a3c_96e1 // Entry key, arbitrary value
)
(
   input wire logic i_clk, // System clock, 200 MHz
   input wire logic i_reset_n, // Synchronous reset, active low
   input wire logic i_clk_en, // System clock enable
   input wire logic i_prog_serial_clock, // Link clock from the programmer
   input wire logic i_prog_serial_data, // Data pin level
   output logic o_prog_serial_data, // Data pin drive value
   output logic o_prog_serial_data_oe, // Data pin output enable
   input wire logic i_master_clear_prog_voltage_n, // Master clear pin logic level, low = held
   input wire logic i_master_clear_prog_voltage_hv, // Master clear pin at programming voltage
   input wire logic i_low_voltage_prog_enable_cfg, // Stored enable bit, taken at reset
   input wire logic i_master_clear_reset_cfg, // Configured master clear reset enable
   output logic o_low_voltage_prog_enable, // Live low-voltage enable bit
   output logic o_master_clear_reset_enable, // Effective master clear reset enable
   output logic o_program_mode, // Session active
   output logic o_high_voltage_session, // Session entered at high voltage
   output logic o_wr_valid, // One-cycle write strobe
   output spme_pkg::spme_target_e o_wr_target, // Write target
   output logic [7:0] o_wr_addr, // Write address
   output logic [15:0] o_wr_data // Write data
);
   import spme_pkg::*;

   // ************************************************************
   // Link clock domain
   // ************************************************************
   logic [2:0] l_rst_sync;
   logic [2:0] l_mode_sync;
   logic [2:0] l_lvp_sync;
   logic [2:0] l_hv_sync;
   logic l_rst_n;
   logic l_mode;
   logic l_lvp;
   logic l_hv;
   logic l_mode_q;
   logic [31:0] l_shift;
   logic l_active;
   logic l_key_ok;
   logic [4:0] l_bit_cnt;
   logic [31:0] l_word;
   logic l_word_tog;
   logic [31:0] l_rd_shift;
   logic [5:0] l_rd_cnt;

   wire [31:0] l_next_shift = {l_shift[30:0], i_prog_serial_data};
   wire l_key_hit = (l_next_shift == KEY_VALUE) && l_lvp && !l_active;
   wire l_word_done = l_active && (l_bit_cnt == LAST_BIT);
   wire l_rd_cmd = l_word_done && (l_next_shift[CMD_MSB:CMD_LSB] == CMD_RD_STATUS);
   wire l_mode_fell = l_mode_q && !l_mode;
   wire l_mode_rose = l_mode && !l_mode_q;
   wire [31:0] l_status = {29'h0000_0000, l_hv, l_lvp, l_mode};
   // Levels change once second and third stages agree
   wire l_rst_n_next = (l_rst_sync[1] == l_rst_sync[2]) ? l_rst_sync[2] : l_rst_n;
   wire l_mode_next = (l_mode_sync[1] == l_mode_sync[2]) ? l_mode_sync[2] : l_mode;
   wire l_lvp_next = (l_lvp_sync[1] == l_lvp_sync[2]) ? l_lvp_sync[2] : l_lvp;
   wire l_hv_next = (l_hv_sync[1] == l_hv_sync[2]) ? l_hv_sync[2] : l_hv;

   // Synchronisers for levels coming from the system domain
   always_ff @(posedge i_prog_serial_clock)
   begin
      l_rst_sync <= {l_rst_sync[1:0], i_reset_n};
      l_mode_sync <= {l_mode_sync[1:0], o_program_mode};
      l_lvp_sync <= {l_lvp_sync[1:0], o_low_voltage_prog_enable};
      l_hv_sync <= {l_hv_sync[1:0], o_high_voltage_session};
      l_rst_n <= l_rst_n_next;
      l_mode <= l_mode_next;
      l_lvp <= l_lvp_next;
      l_hv <= l_hv_next;
   end

   // Key shifter, always running
   // shift MSB first
   always_ff @(posedge i_prog_serial_clock)
   begin
      if (!l_rst_n)
         l_shift <= RST_WORD;
      else
         l_shift <= l_next_shift;
   end

   // Session framing on the link side
   always_ff @(posedge i_prog_serial_clock)
   begin
      if (!l_rst_n || l_mode_fell)
      begin
         l_active <= 1'b0;
         l_key_ok <= 1'b0;
         l_bit_cnt <= RST_BIT_CNT;
      end
      else if (l_key_hit)
      begin
         l_active <= 1'b1;
         l_key_ok <= 1'b1;
         l_bit_cnt <= RST_BIT_CNT;
      end
      else if (l_mode_rose && !l_active)
      begin
         l_active <= 1'b1;
         l_bit_cnt <= RST_BIT_CNT;
      end
      else if (l_active)
         l_bit_cnt <= l_bit_cnt + 5'h01;
      l_mode_q <= l_rst_n && l_mode;
   end

   // Word capture and toggle toward the system domain
   // whole words handed over
   always_ff @(posedge i_prog_serial_clock)
   begin
      if (!l_rst_n)
      begin
         l_word <= RST_WORD;
         l_word_tog <= 1'b0;
      end
      else if (l_word_done && l_mode)
      begin
         l_word <= l_next_shift;
         l_word_tog <= !l_word_tog;
      end
   end

   // Readback drive on the shared data pin
   // device drives only during readback
   always_ff @(posedge i_prog_serial_clock)
   begin
      if (!l_rst_n || l_mode_fell)
      begin
         l_rd_shift <= RST_WORD;
         l_rd_cnt <= RST_READ_CNT;
      end
      else if (l_rd_cmd && l_mode)
      begin
         l_rd_shift <= l_status;
         l_rd_cnt <= READ_BITS;
      end
      else if (l_rd_cnt != RST_READ_CNT)
      begin
         l_rd_shift <= {l_rd_shift[30:0], 1'b0};
         l_rd_cnt <= l_rd_cnt - 6'h01;
      end
   end

   assign o_prog_serial_data = l_rd_shift[31];
   assign o_prog_serial_data_oe = (l_rd_cnt != RST_READ_CNT);

   // ************************************************************
   // System clock domain
   // ************************************************************
   typedef enum logic [1:0] {SPME_IDLE, SPME_HV_SESSION, SPME_LV_SESSION} spme_state_e;
   localparam int N_IN = 6;
   localparam int IN_MCLR_N = 0;
   localparam int IN_HV = 1;
   localparam int IN_DATA = 2;
   localparam int IN_CLOCK = 3;
   localparam int IN_KEY_OK = 4;
   localparam int IN_WORD_TOG = 5;

   spme_state_e state;
   spme_state_e next_state;
   logic [N_IN-1:0] raw_in;
   wire [N_IN-1:0] filt;
   logic hv_prev;
   logic tog_prev;
   logic low_voltage_prog_enable;
   logic next_lvp;

   assign raw_in = {l_word_tog, l_key_ok, i_prog_serial_clock, i_prog_serial_data,
                    i_master_clear_prog_voltage_hv, i_master_clear_prog_voltage_n};

   // Three-stage synchroniser per asynchronous input
   genvar gi;
   generate
      for (gi = 0; gi < N_IN; gi++)
      begin : g_sync
         logic [2:0] stage;
         logic level;
         always_ff @(posedge i_clk)
         begin
            if (!i_reset_n)
            begin
               stage <= RST_SYNC;
               level <= (gi == IN_MCLR_N) ? 1'b1 : 1'b0;
            end
            else if (i_clk_en)
            begin
               stage <= {stage[1:0], raw_in[gi]};
               if (stage[1] == stage[2])
                  level <= stage[2];
            end
         end
         // One process per filtered bit, gathered onto the shared vector
         assign filt[gi] = level;
      end
   endgenerate

   // Entry and exit conditions
   // lines low then high voltage
   wire hv_entry = filt[IN_HV] && !hv_prev && !filt[IN_CLOCK] && !filt[IN_DATA];
   // master clear low and key taken
   wire lv_entry = !filt[IN_MCLR_N] && filt[IN_KEY_OK] && low_voltage_prog_enable;
   wire word_new = (filt[IN_WORD_TOG] != tog_prev) && (state != SPME_IDLE);
   wire [7:0] w_cmd = l_word[CMD_MSB:CMD_LSB];
   wire [7:0] w_addr = l_word[ADDR_MSB:ADDR_LSB];
   wire [15:0] w_data = l_word[DATA_MSB:DATA_LSB];
   wire is_prog = (w_cmd == CMD_WR_PROGRAM);
   wire is_uid = (w_cmd == CMD_WR_USER_ID);
   wire is_cfg = (w_cmd == CMD_WR_CONFIG);
   wire is_write = is_prog || is_uid || is_cfg;
   wire lvp_write = word_new && is_cfg && (w_addr == CFG_ADDR_LVP);
   wire lvp_value = w_data[LVP_DATA_BIT];

   // Session state machine
   always_comb
   begin
      next_state = state;
      case (state)
         SPME_IDLE:
            if (hv_entry)
               next_state = SPME_HV_SESSION;
            else if (lv_entry)
               next_state = SPME_LV_SESSION;
         SPME_HV_SESSION:
            if (!filt[IN_HV])
               next_state = SPME_IDLE;
         SPME_LV_SESSION:
            if (filt[IN_MCLR_N])
               next_state = SPME_IDLE;
         default:
            next_state = SPME_IDLE;
      endcase
   end

   // Enable bit update
   always_comb
   begin
      next_lvp = low_voltage_prog_enable;
      if (lvp_write && lvp_value)
         next_lvp = 1'b1;
      else if (lvp_write && (state == SPME_HV_SESSION))
         next_lvp = 1'b0;
   end

   // State, enable bit and edge history
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         state <= SPME_IDLE;
         low_voltage_prog_enable <= i_low_voltage_prog_enable_cfg;
         hv_prev <= 1'b0;
         tog_prev <= 1'b0;
      end
      else if (i_clk_en)
      begin
         state <= next_state;
         low_voltage_prog_enable <= next_lvp;
         hv_prev <= filt[IN_HV];
         tog_prev <= filt[IN_WORD_TOG];
      end
   end

   // Registered outputs
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_program_mode <= 1'b0;
         o_high_voltage_session <= 1'b0;
         o_low_voltage_prog_enable <= 1'b0;
         o_master_clear_reset_enable <= 1'b1;
      end
      else if (i_clk_en)
      begin
         o_program_mode <= (next_state != SPME_IDLE);
         o_high_voltage_session <= (next_state == SPME_HV_SESSION);
         o_low_voltage_prog_enable <= next_lvp;
         o_master_clear_reset_enable <= next_lvp || i_master_clear_reset_cfg;
      end
   end

   // Write strobe toward memory, word is stable while its toggle settles
   // program, user id and config writes
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_wr_valid <= 1'b0;
         o_wr_target <= SPME_TGT_PROGRAM;
         o_wr_addr <= 8'h00;
         o_wr_data <= 16'h0000;
      end
      else if (i_clk_en)
      begin
         o_wr_valid <= word_new && is_write;
         if (word_new && is_write)
         begin
            o_wr_target <= is_prog ? SPME_TGT_PROGRAM : (is_uid ? SPME_TGT_USER_ID : SPME_TGT_CONFIG);
            o_wr_addr <= w_addr;
            o_wr_data <= w_data;
         end
      end
   end
endmodule

// ==== sim/spme_checker.sv ====
// Port checker for serial program mode entry
`timescale 1ns/1ps
module spme_checker (
   input wire logic i_clk, // Clock
   input wire logic i_reset_n, // Reset
   input wire logic i_prog_serial_clock, // Link clock
   input wire logic i_prog_serial_data, // Pin
   input wire logic i_master_clear_prog_voltage_n, // Clear
   input wire logic i_master_clear_prog_voltage_hv, // High voltage
   input logic o_prog_serial_data_oe, // Enable
   input logic o_low_voltage_prog_enable, // Enable bit
   input logic o_master_clear_reset_enable, // Clear enable
   input logic o_program_mode, // Session
   input logic o_high_voltage_session, // HV session
   input logic o_wr_valid // Strobe
);
   // ************************************************************
   // Session checks
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   // Clock and data low with master clear at programming level
   wire hv_pins_low = !i_prog_serial_clock && !i_prog_serial_data && i_master_clear_prog_voltage_hv;
   // Entry pins held for the three cycles before the session flag
   sequence s_hv_pins;
      $past(hv_pins_low, 3) && $past(hv_pins_low, 2) && $past(hv_pins_low);
   endsequence
   a_hv_entry_pins: assert property ($rose(o_high_voltage_session) |-> s_hv_pins)
      else $error("hv entry without pins low");
   a_hv_mode_together: assert property ($rose(o_high_voltage_session) |-> $rose(o_program_mode))
      else $error("hv flag and mode apart");
   a_lv_needs_enable: assert property (o_program_mode && !o_high_voltage_session |-> o_low_voltage_prog_enable)
      else $error("lv session with bit clear");
   a_lv_pin_low: assert property (o_program_mode && !o_high_voltage_session |->
      $past(i_master_clear_prog_voltage_n, 6) == 1'b0)
      else $error("lv session with clear high");
   a_clear_forced: assert property (o_low_voltage_prog_enable && $past(o_low_voltage_prog_enable) |->
      o_master_clear_reset_enable)
      else $error("clear reset not forced");
   a_clear_in_hv: assert property ($fell(o_low_voltage_prog_enable) |-> $past(o_high_voltage_session))
      else $error("bit cleared outside hv");
   a_hv_exit_cause: assert property ($fell(o_program_mode) && $past(o_high_voltage_session) |->
      !$past(i_master_clear_prog_voltage_hv, 3))
      else $error("hv exit without cause");
   a_lv_exit_cause: assert property ($fell(o_program_mode) && !$past(o_high_voltage_session) |->
      $past(i_master_clear_prog_voltage_n, 3))
      else $error("lv exit without cause");
   a_strobe_in_mode: assert property (o_wr_valid |-> o_program_mode ##1 !o_wr_valid)
      else $error("bad write strobe");
   a_drive_in_mode: assert property (o_prog_serial_data_oe |-> o_program_mode)
      else $error("pin driven outside session");
endmodule

// ==== sim/spme_prog_model.sv ====
// Programmer model driving the link clock and data pin
`timescale 1ns/1ps
module spme_prog_model (
   output logic o_sck, // Link clock
   output logic o_sd, // Data drive
   output logic o_sd_oe, // Data enable
   input wire logic i_sd // Pin level
);
   // Clock still, data driven low until the first frame
   initial
   begin
      o_sck = 1'b0;
      o_sd = 1'b0;
      o_sd_oe = 1'b1;
   end
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         o_sd = w[i];
         #16 o_sck = 1'b1;
         #16 o_sck = 1'b0;
      end
   endtask
   // Idle clocks with data low
   task automatic idle(input int n);
      repeat (n) send_bit();
   endtask
   task automatic send_bit();
      o_sd = 1'b0;
      #16 o_sck = 1'b1;
      #16 o_sck = 1'b0;
   endtask
   task automatic hold(input logic b);
      o_sd = b;
   endtask
   // Release pin, sample each bit just before the rise that shifts it out
   task automatic rd(output logic [31:0] s);
      o_sd_oe = 1'b0;
      repeat (32)
      begin
         #15 s = {s[30:0], i_sd};
         #1 o_sck = 1'b1;
         #16 o_sck = 1'b0;
      end
      o_sd_oe = 1'b1;
   endtask
endmodule

// ==== sim/spme_top_tb.sv ====
// Testbench for serial program mode entry
`timescale 1ns/1ps
module spme_top_tb;
   import spme_pkg::*;
   localparam logic [31:0] KEY = 32'h5a3c_96e1; // Arbitrary key
   logic i_clk, i_reset_n, cen, mclr_n, hv, lcfg, mcfg, sck, psd, poe, dsd, doe, low_voltage_prog_enable, mcen, mode, hvs, wv, pin;
   spme_target_e tgt;
   logic [7:0] wa;
   logic [15:0] wd;
   logic [25:0] fld;
   logic [31:0] s;
   int n_fail = 0, cmp_count = 0, n_wr = 0;
   // Rows: lvp cfg, clear cfg, expected bit, expected clear enable
   logic [3:0] rows [4] = '{4'hf, 4'hb, 4'h5, 4'h0};
   always #2.5 i_clk = ~i_clk;
   // Wire level: toggling pattern when nobody drives
   assign pin = doe ? dsd : (poe ? psd : i_clk);
   spme_top #(.KEY_VALUE(KEY)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(cen),
      .i_prog_serial_clock(sck), .i_prog_serial_data(pin), .o_prog_serial_data(dsd),
      .o_prog_serial_data_oe(doe), .i_master_clear_prog_voltage_n(mclr_n),
      .i_master_clear_prog_voltage_hv(hv), .i_low_voltage_prog_enable_cfg(lcfg),
      .i_master_clear_reset_cfg(mcfg), .o_low_voltage_prog_enable(low_voltage_prog_enable),
      .o_master_clear_reset_enable(mcen), .o_program_mode(mode), .o_high_voltage_session(hvs),
      .o_wr_valid(wv), .o_wr_target(tgt), .o_wr_addr(wa), .o_wr_data(wd));
   spme_prog_model u_prog (.o_sck(sck), .o_sd(psd), .o_sd_oe(poe), .i_sd(pin));
   // Strobe monitor
   always @(posedge i_clk)
      if (wv === 1'b1)
      begin
         n_wr <= n_wr + 1;
         fld <= {tgt, wa, wd};
      end
   task automatic stop_test();
      $display("Checks %0d errors %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic rst(input logic l, input logic m);
      i_reset_n = 1'b0;
      lcfg = l;
      mcfg = m;
      u_prog.idle(6);
      cyc(1);
      i_reset_n = 1'b1;
      // Link side leaves reset only on link edges
      u_prog.idle(6);
      cyc(8);
   endtask
   task automatic wait_mode(input logic e);
      for (int i = 0; i < 40 && mode !== e; i++)
         cyc(1);
      chk(mode, e);
      if (mode !== e)
         stop_test();
   endtask
   // Word out, then expected strobe flag and fields
   task automatic word(input logic [31:0] w, input logic [31:0] e);
      int n0;
      logic [31:0] g;
      n0 = n_wr;
      u_prog.send(w);
      for (int i = 0; i < 20 && n_wr == n0; i++)
         cyc(1);
      cyc(2);
      g = {n_wr != n0, 5'h0, fld};
      chk(e[31] ? g : {g[31], 31'h0}, e);
   endtask
   initial
   begin
      #100000;
      n_fail++;
      stop_test();
   end
   // Main sequence
   initial
   begin
      i_clk = 1'b0;
      cen = 1'b1;
      mclr_n = 1'b1;
      hv = 1'b0;
      for (int r = 0; r < 4; r++)
      begin
         rst(rows[r][3], rows[r][2]);
         chk(low_voltage_prog_enable, rows[r][1]);
         chk(mcen, rows[r][0]);
         chk(mode, 1'b0);
      end
      mclr_n = 1'b0;
      u_prog.send(KEY);
      cyc(20);
      chk(mode, 1'b0);
      rst(1'b1, 1'b0);
      mclr_n = 1'b0;
      u_prog.send(KEY ^ 32'h1);
      cyc(20);
      chk(mode, 1'b0);
      u_prog.send(KEY);
      wait_mode(1'b1);
      word(32'h0212_abcd, {6'h20, SPME_TGT_PROGRAM, 24'h12_abcd});
      word(32'h0334_5678, {6'h20, SPME_TGT_USER_ID, 24'h34_5678});
      word(32'h0700_0000, 32'h0);
      word(32'h0400_0000, {6'h20, SPME_TGT_CONFIG, 24'h0});
      chk(low_voltage_prog_enable, 1'b1);
      u_prog.send(32'h0500_0000);
      u_prog.rd(s);
      chk(s, 32'h3);
      cyc(1);
      mclr_n = 1'b1;
      wait_mode(1'b0);
      // Idle link clocks so the link side sees the session end
      u_prog.idle(6);
      u_prog.hold(1'b1);
      hv = 1'b1;
      cyc(20);
      chk(mode, 1'b0);
      hv = 1'b0;
      u_prog.hold(1'b0);
      cyc(10);
      hv = 1'b1;
      wait_mode(1'b1);
      chk(hvs, 1'b1);
      // Five link edges before the link side starts counting word bits
      u_prog.idle(5);
      word(32'h0400_0000, {6'h20, SPME_TGT_CONFIG, 24'h0});
      chk({low_voltage_prog_enable, mcen}, 2'h0);
      cyc(1);
      // Clock enable low freezes the session across the pin change
      cen = 1'b0;
      hv = 1'b0;
      cyc(20);
      chk(mode, 1'b1);
      cen = 1'b1;
      wait_mode(1'b0);
      stop_test();
   end
endmodule
bind spme_top spme_checker u_chk (.*);
